// ===== logic/uis_pkg.sv
// shared constants for the usb interrupt status block
package uis_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_LINE = 12'h024;
  localparam int BIT_BUS_RESET = 10;
  localparam int BIT_RESUME = 9;
  localparam int BIT_SUSPEND = 8;
  localparam int BIT_EP0 = 0;
  localparam int BIT_EP_LO = 1;
  localparam int LINE_BIT_WOKE = 0;
  localparam int LINE_BIT_WAIT = 1;
  localparam logic [31:0] PENDING_RST = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RST = 32'h0000_041F;
  localparam logic [31:0] FLAG_MASK = 32'h0000_071F;
  localparam int NUM_EP = 4;
  localparam int CLK_KHZ = 25000;
  localparam int IDLE_TIME_US = 3000;
  localparam int SE0_TIME_US = 3000;
  localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_KHZ / 1000;
  localparam int SE0_CYCLES = SE0_TIME_US * CLK_KHZ / 1000;
endpackage

// ===== logic/uis_ep_if.sv
// endpoint handshake bits and event pulses between top and detectors
`timescale 1ns/1ps
interface uis_data_if;
  logic in_packet_ready;
  logic in_underrun;
  logic out_sent_stall;
  logic in_sent_stall;
  logic fifo_flush;
  logic iso_mode;
  logic evt;
  modport det(input in_packet_ready, input in_underrun, input out_sent_stall,
    input in_sent_stall, input fifo_flush, input iso_mode, output evt);
  modport owner(output in_packet_ready, output in_underrun, output out_sent_stall,
    output in_sent_stall, output fifo_flush, output iso_mode, input evt);
endinterface

interface uis_ctrl_if;
  logic ctrl_out_ready;
  logic ctrl_in_ready;
  logic ctrl_sent_stall;
  logic setup_end;
  logic data_end;
  logic evt;
  modport det(input ctrl_out_ready, input ctrl_in_ready, input ctrl_sent_stall,
    input setup_end, input data_end, output evt);
  modport owner(output ctrl_out_ready, output ctrl_in_ready, output ctrl_sent_stall,
    output setup_end, output data_end, input evt);
endinterface

// ===== logic/uis_data_ep.sv
// event detector for one bulk or isochronous endpoint
`timescale 1ns/1ps
module uis_data_ep (
  input wire logic pclk,
  input wire logic presetn,
  uis_data_if.det ep
);
  typedef struct packed {
    logic ctrl_in_ready_prev;
    logic under_prev;
    logic ostall_prev;
    logic istall_prev;
    logic evt;
  } uis_data_state_t;

  localparam uis_data_state_t RST = '0;
  uis_data_state_t st_reg;
  uis_data_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.ctrl_in_ready_prev = ep.in_packet_ready;
    st_next.under_prev = ep.in_underrun;
    st_next.ostall_prev = ep.out_sent_stall;
    st_next.istall_prev = ep.in_sent_stall;
    // stall of either direction counts
    st_next.evt = (st_reg.ctrl_in_ready_prev & ~ep.in_packet_ready) | ep.fifo_flush
      | (~st_reg.ostall_prev & ep.out_sent_stall)
      | (~st_reg.istall_prev & ep.in_sent_stall)
      | (ep.iso_mode & ~st_reg.under_prev & ep.in_underrun);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ep.evt = st_reg.evt;
endmodule

// ===== logic/uis_ctrl_ep.sv
// event detector for the control endpoint
`timescale 1ns/1ps
module uis_ctrl_ep (
  input wire logic pclk,
  input wire logic presetn,
  uis_ctrl_if.det ep
);
  typedef struct packed {
    logic ctrl_out_ready_prev;
    logic irdy_prev;
    logic stall_prev;
    logic setup_end_prev;
    logic data_end_prev;
    logic evt;
  } uis_ctrl_state_t;

  localparam uis_ctrl_state_t RST = '0;
  uis_ctrl_state_t st_reg;
  uis_ctrl_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.ctrl_out_ready_prev = ep.ctrl_out_ready;
    st_next.irdy_prev = ep.ctrl_in_ready;
    st_next.stall_prev = ep.ctrl_sent_stall;
    st_next.setup_end_prev = ep.setup_end;
    st_next.data_end_prev = ep.data_end;
    st_next.evt = (~st_reg.ctrl_out_ready_prev & ep.ctrl_out_ready)
      | (st_reg.irdy_prev & ~ep.ctrl_in_ready)
      | (~st_reg.stall_prev & ep.ctrl_sent_stall)
      | (~st_reg.setup_end_prev & ep.setup_end)
      | (st_reg.data_end_prev & ~ep.data_end);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ep.evt = st_reg.evt;
endmodule

// ===== logic/uis_top.sv
// usb interrupt status collector with apb register access
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module uis_top #(
  parameter int IDLE_CYCLES = uis_pkg::IDLE_CYCLES,
  parameter int SE0_CYCLES = uis_pkg::SE0_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uis_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic line_active,
  input wire logic line_se0,
  input wire logic func_suspended,
  input wire logic clocks_running,
  input wire logic ctrl_out_ready,
  input wire logic ctrl_in_ready,
  input wire logic ctrl_sent_stall,
  input wire logic setup_end,
  input wire logic data_end,
  input wire logic [uis_pkg::NUM_EP:1] in_packet_ready,
  input wire logic [uis_pkg::NUM_EP:1] in_underrun,
  input wire logic [uis_pkg::NUM_EP:1] out_sent_stall,
  input wire logic [uis_pkg::NUM_EP:1] in_sent_stall,
  input wire logic [uis_pkg::NUM_EP:1] fifo_flush,
  input wire logic [uis_pkg::NUM_EP:1] iso_mode
);
  localparam int CNT_W = $clog2((IDLE_CYCLES > SE0_CYCLES ? IDLE_CYCLES : SE0_CYCLES) + 1);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SE0_LAST = CNT_W'(SE0_CYCLES - 1);

  if (IDLE_CYCLES < 2 || SE0_CYCLES < 2) begin : g_bad_count
    $error("uis_top: idle and se0 counts must be at least 2");
  end

  typedef struct packed {
    logic [31:0] pending;
    logic [31:0] enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] se0_cnt;
    logic se0_prev;
    logic wake_wait;
    logic woke;
  } uis_state_t;

  localparam uis_state_t RST = '{
    pending: uis_pkg::PENDING_RST,
    enable: uis_pkg::ENABLE_RST,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0,
    irq: 1'b0,
    idle_cnt: '0,
    se0_cnt: '0,
    se0_prev: 1'b0,
    wake_wait: 1'b0,
    woke: 1'b0
  };

  uis_state_t st_reg;
  uis_state_t st_next;
  logic [uis_pkg::NUM_EP:1] ep_evt;
  logic ep0_evt;

  uis_ctrl_if cif();
  assign cif.ctrl_out_ready = ctrl_out_ready;
  assign cif.ctrl_in_ready = ctrl_in_ready;
  assign cif.ctrl_sent_stall = ctrl_sent_stall;
  assign cif.setup_end = setup_end;
  assign cif.data_end = data_end;
  assign ep0_evt = cif.evt;

  uis_ctrl_ep u_ctrl_ep (
    .pclk(pclk),
    .presetn(presetn),
    .ep(cif)
  );

  for (genvar i = 1; i <= uis_pkg::NUM_EP; i++) begin : g_ep
    uis_data_if dif();
    assign dif.in_packet_ready = in_packet_ready[i];
    assign dif.in_underrun = in_underrun[i];
    assign dif.out_sent_stall = out_sent_stall[i];
    assign dif.in_sent_stall = in_sent_stall[i];
    assign dif.fifo_flush = fifo_flush[i];
    assign dif.iso_mode = iso_mode[i];
    assign ep_evt[i] = dif.evt;

    uis_data_ep u_data_ep (
      .pclk(pclk),
      .presetn(presetn),
      .ep(dif)
    );
  end

  function automatic logic hit(input logic [uis_pkg::ADDR_W-1:0] a,
                               input logic [uis_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [uis_pkg::ADDR_W-1:0] a);
    mapped = hit(a, uis_pkg::OFF_PENDING) || hit(a, uis_pkg::OFF_ENABLE)
      || hit(a, uis_pkg::OFF_CLEAR) || hit(a, uis_pkg::OFF_LINE);
  endfunction

  always_comb begin
    logic active;
    logic rst_evt;
    logic res_evt;
    logic sus_evt;
    logic setup;
    logic access;
    logic [31:0] events;
    logic [31:0] clr;
    logic [31:0] rd;
    active = line_active | line_se0;
    rst_evt = 1'b0;
    res_evt = 1'b0;
    sus_evt = 1'b0;
    setup = psel & ~penable;
    access = psel & penable & st_reg.pready;
    events = 32'h0000_0000;
    clr = 32'h0000_0000;
    rd = 32'h0000_0000;
    st_next = st_reg;

    // wake from suspend by any bus activity
    if (func_suspended && !st_reg.woke && active) begin
      res_evt = 1'b1;
      st_next.woke = 1'b1;
      st_next.wake_wait = line_se0;
      st_next.se0_cnt = '0;
    end else if (!func_suspended && !st_reg.wake_wait) begin
      st_next.woke = 1'b0;
    end

    // reset after a wake waits for long se0 with clocks up
    if (st_reg.wake_wait) begin
      if (!line_se0) begin
        st_next.wake_wait = 1'b0;
        st_next.se0_cnt = '0;
      end else if (clocks_running) begin
        if (st_reg.se0_cnt == SE0_LAST) begin
          rst_evt = 1'b1;
          st_next.wake_wait = 1'b0;
          st_next.se0_cnt = '0;
        end else begin
          st_next.se0_cnt = st_reg.se0_cnt + 1'b1;
        end
      end
    end else if (line_se0 && !st_reg.se0_prev && !func_suspended) begin
      rst_evt = 1'b1;
    end
    st_next.se0_prev = line_se0;

    // idle timer restarts after each suspend event
    if (active) begin
      st_next.idle_cnt = '0;
    end else if (st_reg.idle_cnt == IDLE_LAST) begin
      sus_evt = 1'b1;
      st_next.idle_cnt = '0;
    end else begin
      st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
    end

    events[uis_pkg::BIT_BUS_RESET] = rst_evt;
    events[uis_pkg::BIT_RESUME] = res_evt;
    events[uis_pkg::BIT_SUSPEND] = sus_evt;
    events[uis_pkg::BIT_EP0] = ep0_evt;
    events[uis_pkg::BIT_EP_LO +: uis_pkg::NUM_EP] = ep_evt;

    // register writes take effect at the access edge
    if (access && pwrite) begin
      if (hit(paddr, uis_pkg::OFF_PENDING) || hit(paddr, uis_pkg::OFF_CLEAR)) begin
        clr = pwdata & uis_pkg::FLAG_MASK;
      end else if (hit(paddr, uis_pkg::OFF_ENABLE)) begin
        st_next.enable = pwdata & uis_pkg::FLAG_MASK;
      end
    end
    // a new event wins over a clear in the same cycle
    st_next.pending = ((st_reg.pending & ~clr) | events) & uis_pkg::FLAG_MASK;

    // read data captured in the setup cycle
    if (hit(paddr, uis_pkg::OFF_PENDING)) begin
      rd = st_reg.pending;
    end else if (hit(paddr, uis_pkg::OFF_ENABLE)) begin
      rd = st_reg.enable;
    end else if (hit(paddr, uis_pkg::OFF_LINE)) begin
      rd[uis_pkg::LINE_BIT_WOKE] = st_reg.woke;
      rd[uis_pkg::LINE_BIT_WAIT] = st_reg.wake_wait;
    end
    st_next.pready = setup;
    st_next.pslverr = setup & ~mapped(paddr);
    st_next.prdata = (setup && !pwrite) ? rd : 32'h0000_0000;

    st_next.irq = |(st_next.pending & st_next.enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
endmodule

// ===== sim/uis_top_chk.sv
// assertions on the usb interrupt status top ports
`timescale 1ns/1ps
module uis_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uis_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late or long");
  property p_only; pready |-> psel && penable; endproperty
  a_only: assert property (p_only) else $error("pready outside access");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  property p_rsvd; pready |-> prdata[31:11] == 21'h0 && prdata[7:5] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read one");
  property p_map; pready && paddr == uis_pkg::OFF_PENDING |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("error on pending access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_hold; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
  a_hold: assert property (p_hold) else $error("irq fell without write");
  property p_clr; pready && !pwrite && paddr == uis_pkg::OFF_CLEAR |-> prdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear register read nonzero");
endmodule
bind uis_top uis_top_chk u_uis_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .irq);

// ===== sim/uis_engine_model.sv
// model of the usb engine and endpoint logic driving event lines
`timescale 1ns/1ps
module uis_engine_model (
  input wire logic pclk,
  output logic line_active,
  output logic line_se0,
  output logic func_suspended,
  output logic clocks_running,
  output logic [4:0] ctrl_bits,
  output logic [4:0][4:1] ev_bits,
  output logic [4:1] iso_mode
);
  initial begin
    {line_active, line_se0, func_suspended, clocks_running} = 4'h8;
    ctrl_bits = '0;
    ev_bits = '0;
    iso_mode = '0;
  end
  task set_line(input logic a, input logic s, input logic f, input logic c);
    @(posedge pclk);
    {line_active, line_se0, func_suspended, clocks_running} <= {a, s, f, c};
  endtask
  // one bit raised then dropped, so underrun and ready-clear never coincide
  task ep_evt(input int e, input int k, input logic iso);
    @(posedge pclk);
    if (e > 0) iso_mode[e] <= iso;
    @(posedge pclk);
    if (e == 0) ctrl_bits[k] <= 1'h1;
    else ev_bits[k][e] <= 1'h1;
    @(posedge pclk);
    ctrl_bits <= '0;
    ev_bits <= '0;
    repeat (4) @(posedge pclk);
    iso_mode <= '0;
  endtask
endmodule

// ===== sim/tb_usb_device_interrupt_status.sv
// testbench for the usb interrupt status block
`timescale 1ns/1ps
module tb_usb_device_interrupt_status;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, errv;
  logic [uis_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic la, se0, susp, clkr;
  logic [4:0] cb;
  logic [4:0][4:1] ev;
  logic [4:1] iso;
  int miscompares = 0;
  int total_checks = 0;
  always #20 pclk = ~pclk;
  uis_top #(.IDLE_CYCLES(20), .SE0_CYCLES(20)) u_uis_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .line_active(la),
    .line_se0(se0), .func_suspended(susp), .clocks_running(clkr), .ctrl_out_ready(cb[0]),
    .ctrl_in_ready(cb[1]), .ctrl_sent_stall(cb[2]), .setup_end(cb[3]), .data_end(cb[4]),
    .in_packet_ready(ev[0]), .fifo_flush(ev[1]), .out_sent_stall(ev[2]),
    .in_sent_stall(ev[3]), .in_underrun(ev[4]), .iso_mode(iso));
  uis_engine_model u_uis_engine_model (.pclk(pclk), .line_active(la), .line_se0(se0),
    .func_suspended(susp), .clocks_running(clkr), .ctrl_bits(cb), .ev_bits(ev),
    .iso_mode(iso));
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [uis_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      miscompares++;
      $display("mismatch at %0t: no pready", $time);
      wrap_up();
    end
  endtask
  task rd(input logic [uis_pkg::ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'h0, a, 32'h0);
    chk(rdv & m, exp);
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(uis_pkg::OFF_PENDING, 32'h0, 32'hFFFF_FFFF);
    rd(uis_pkg::OFF_ENABLE, uis_pkg::ENABLE_RST, 32'hFFFF_FFFF);
    apb(1'h0, 12'h100, 32'h0);
    chk({31'h0, errv}, 32'h1);
    apb(1'h1, uis_pkg::OFF_ENABLE, 32'hFFFF_FFFF);
    rd(uis_pkg::OFF_ENABLE, 32'h0000_071F, 32'hFFFF_FFFF);
    rd(uis_pkg::OFF_CLEAR, 32'h0, 32'hFFFF_FFFF);
    apb(1'h1, uis_pkg::OFF_ENABLE, uis_pkg::ENABLE_RST);
    $display("test registers done");
    u_uis_engine_model.set_line(1'h0, 1'h0, 1'h0, 1'h0);
    repeat (22) @(posedge pclk);
    rd(uis_pkg::OFF_PENDING, 32'h100, 32'h100);
    apb(1'h1, uis_pkg::OFF_PENDING, 32'h100);
    rd(uis_pkg::OFF_PENDING, 32'h0, 32'h100);
    repeat (12) @(posedge pclk);
    rd(uis_pkg::OFF_PENDING, 32'h100, 32'h100);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, uis_pkg::OFF_ENABLE, 32'h100);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    u_uis_engine_model.set_line(1'h1, 1'h0, 1'h0, 1'h0);
    apb(1'h1, uis_pkg::OFF_PENDING, 32'h71F);
    apb(1'h1, uis_pkg::OFF_ENABLE, uis_pkg::ENABLE_RST);
    $display("test suspend done");
    u_uis_engine_model.set_line(1'h1, 1'h1, 1'h0, 1'h0);
    repeat (3) @(posedge pclk);
    rd(uis_pkg::OFF_PENDING, 32'h400, 32'h700);
    u_uis_engine_model.set_line(1'h1, 1'h0, 1'h0, 1'h0);
    apb(1'h1, uis_pkg::OFF_PENDING, 32'h71F);
    u_uis_engine_model.set_line(1'h0, 1'h1, 1'h1, 1'h0);
    repeat (3) @(posedge pclk);
    rd(uis_pkg::OFF_PENDING, 32'h200, 32'h600);
    rd(uis_pkg::OFF_LINE, 32'h3, 32'h3);
    u_uis_engine_model.set_line(1'h0, 1'h1, 1'h1, 1'h1);
    repeat (24) @(posedge pclk);
    rd(uis_pkg::OFF_PENDING, 32'h600, 32'h600);
    rd(uis_pkg::OFF_LINE, 32'h1, 32'h3);
    u_uis_engine_model.set_line(1'h1, 1'h0, 1'h0, 1'h1);
    apb(1'h1, uis_pkg::OFF_PENDING, 32'h71F);
    $display("test line done");
    for (int e = 0; e < 5; e++) begin
      for (int k = 0; k < 5; k++) begin
        u_uis_engine_model.ep_evt(e, k, k == 4);
        rd(uis_pkg::OFF_PENDING, 32'h1 << e, 32'h1F);
        apb(1'h1, uis_pkg::OFF_CLEAR, 32'h1 << e);
      end
    end
    u_uis_engine_model.ep_evt(1, 4, 1'h0);
    rd(uis_pkg::OFF_PENDING, 32'h0, 32'h1F);
    $display("test endpoints done");
    wrap_up();
  end
endmodule
